// >>> design/alarm_out_irq.v
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "alarm_irq_map.vh"
module alarm_out_irq (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Token from the SIE
  input  wire        token_valid,
  input  wire        token_is_ping,
  input  wire [3:0]  token_ep,
  input  wire        high_speed_operation,
  input  wire        sleep_state,
  // Endpoint configuration
  input  wire [15:0] out_endpoint_enable_mask,
  input  wire [15:0] out_endpoint_iso_select,
  input  wire [15:0] area_endpoint_join_bit,
  // Cause groups
  input  wire [7:0]  sie_cause,
  input  wire [7:0]  bulk_cause,
  input  wire [7:0]  ep0_cause,
  input  wire [4:0]  ep_cause_any,
  input  wire        unjoined_in_any,
  // Handshake answer
  output reg         reply_valid,
  output reg  [1:0]  reply_kind,
  output reg         reply_drop_data,
  // Summaries
  output reg         sie_cause_summary,
  output reg         bulk_cause_summary,
  output reg         endpoint_cause_summary,
  output reg         ep0_cause_summary,
  output reg         irq
);

  reg  [15:0] unjoined_out_flag_ff;
  reg  [7:0]  sie_en_ff;
  reg  [7:0]  bulk_en_ff;
  reg  [7:0]  epsum_en_ff;
  reg  [7:0]  ep0_en_ff;
  reg  [3:0]  irq_stat_ff;
  reg  [3:0]  irq_mask_ff;
  reg  [15:0] nxt_unjoined_out_flag;
  reg  [3:0]  nxt_irq_stat;
  reg  [31:0] nxt_prdata;
  reg         nxt_pslverr;
  wire        wr_en;
  wire        rd_en;
  wire [7:0]  addr;
  wire [7:0]  wbyte;
  wire        ep_enabled;
  wire        ep_joined;
  wire        alarm_hit;
  wire        sie_any;
  wire        bulk_any;
  wire        ep0_any;
  wire        epsum_any;
  wire [7:0]  sie_gate;
  wire [7:0]  epsum_cause;
  wire [3:0]  summaries;
  wire        mapped;
  wire        acc_en;
  wire        addr_in_range;
  wire        hit_flag_high;
  wire        hit_flag_low;
  wire        hit_sie_en;
  wire        hit_bulk_en;
  wire        hit_epsum_en;
  wire        hit_ep0_en;
  wire        hit_irq_stat;
  wire        hit_irq_mask;
  wire        hit_cause_view;
  wire        token_iso;
  wire        reply_wanted;
  reg  [1:0]  apb_state_ff;
  reg  [1:0]  nxt_apb_state;
  reg         nxt_pready;
  reg         nxt_reply_valid;
  reg  [1:0]  nxt_reply_kind;
  reg         nxt_reply_drop_data;
  reg  [7:0]  nxt_sie_en;
  reg  [7:0]  nxt_bulk_en;
  reg  [7:0]  nxt_epsum_en;
  reg  [7:0]  nxt_ep0_en;
  reg  [3:0]  nxt_irq_mask;
  reg         nxt_irq;

  // One-hot bus phases
  localparam [1:0] APB_IDLE = 2'b01;
  localparam [1:0] APB_DONE = 2'b10;

  // Offsets are register indices; the byte address is four times the index
  assign addr          = paddr[9:2];
  assign wbyte         = pwdata[7:0];
  assign addr_in_range = (paddr[11:10] == 2'b00) & (paddr[1:0] == 2'b00);
  // Decode and read data in the first access cycle, answered one cycle later
  assign acc_en = psel & penable & apb_state_ff[0];
  assign rd_en  = acc_en & ~pwrite;
  // Writes land on the answering edge, so no master sees a half-done write
  assign wr_en  = psel & penable & pwrite & pready;

  assign hit_flag_high  = addr_in_range & (addr == `OFS_ALARM_OUT_HIGH);
  assign hit_flag_low   = addr_in_range & (addr == `OFS_ALARM_OUT_LOW);
  assign hit_sie_en     = addr_in_range & (addr == `OFS_SIE_ENABLE);
  assign hit_bulk_en    = addr_in_range & (addr == `OFS_BULK_ENABLE);
  assign hit_epsum_en   = addr_in_range & (addr == `OFS_EP_SUM_ENABLE);
  assign hit_ep0_en     = addr_in_range & (addr == `OFS_EP0_ENABLE);
  assign hit_irq_stat   = addr_in_range & (addr == `OFS_IRQ_STATUS);
  assign hit_irq_mask   = addr_in_range & (addr == `OFS_IRQ_MASK);
  assign hit_cause_view = addr_in_range & (addr == `OFS_CAUSE_VIEW);
  assign mapped = hit_flag_high | hit_flag_low | hit_sie_en | hit_bulk_en |
                  hit_epsum_en | hit_ep0_en | hit_irq_stat | hit_irq_mask |
                  hit_cause_view;

  assign ep_enabled = (token_ep == 4'h0) | out_endpoint_enable_mask[token_ep];
  assign ep_joined  = (token_ep != 4'h0) ? area_endpoint_join_bit[token_ep]
                                         : area_endpoint_join_bit[0];
  assign alarm_hit  = token_valid & ep_enabled & ~ep_joined;
  assign token_iso  = out_endpoint_iso_select[token_ep];
  // Full speed has no PING handshake, so such a token gets no reply at all
  assign reply_wanted = alarm_hit & (~token_is_ping | high_speed_operation);

  // Only non-idle may wake from sleep; others are held off while asleep
  assign sie_gate = sleep_state ? (8'h01 << `BIT_LINE_NOT_IDLE) : 8'hff;
  assign epsum_cause = {unjoined_in_any, (|unjoined_out_flag_ff), 1'b0, ep_cause_any};

  masked_or u_sie (
    .cause  (sie_cause & sie_gate),
    .enable (sie_en_ff),
    .keep   (`MASK_SIE_ENABLE),
    .any    (sie_any)
  );
  masked_or u_bulk (
    .cause  (bulk_cause),
    .enable (bulk_en_ff),
    .keep   (`MASK_BULK_ENABLE),
    .any    (bulk_any)
  );
  masked_or u_epsum (
    .cause  (epsum_cause),
    .enable (epsum_en_ff),
    .keep   (`MASK_EP_SUM_ENABLE),
    .any    (epsum_any)
  );
  masked_or u_ep0 (
    .cause  (ep0_cause),
    .enable (ep0_en_ff),
    .keep   (`MASK_EP0_ENABLE),
    .any    (ep0_any)
  );

  assign summaries = {ep0_any, epsum_any, bulk_any, sie_any};

  always @* begin
    nxt_unjoined_out_flag = unjoined_out_flag_ff;
    if (wr_en && mapped && addr == `OFS_ALARM_OUT_HIGH) begin
      nxt_unjoined_out_flag[15:8] = unjoined_out_flag_ff[15:8] & ~wbyte;
    end
    if (wr_en && mapped && addr == `OFS_ALARM_OUT_LOW) begin
      nxt_unjoined_out_flag[7:0] = unjoined_out_flag_ff[7:0] & ~wbyte;
    end
    // Set after clear so a same-cycle event is never lost
    if (alarm_hit && !token_is_ping) begin
      nxt_unjoined_out_flag[token_ep] = 1'b1;
    end
  end

  always @* begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_en && mapped && addr == `OFS_IRQ_STATUS) begin
      nxt_irq_stat = irq_stat_ff & ~wbyte[3:0];
    end
    nxt_irq_stat = nxt_irq_stat | summaries;
  end

  // Unknown or misaligned words answer with an error and read zero
  always @* begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = acc_en ? ~mapped : 1'b0;
    if (rd_en && hit_flag_high) begin
      nxt_prdata[7:0] = unjoined_out_flag_ff[15:8];
    end
    if (rd_en && hit_flag_low) begin
      nxt_prdata[7:0] = unjoined_out_flag_ff[7:0];
    end
    if (rd_en && hit_sie_en) begin
      nxt_prdata[7:0] = sie_en_ff;
    end
    if (rd_en && hit_bulk_en) begin
      nxt_prdata[7:0] = bulk_en_ff;
    end
    if (rd_en && hit_epsum_en) begin
      nxt_prdata[7:0] = epsum_en_ff;
    end
    if (rd_en && hit_ep0_en) begin
      nxt_prdata[7:0] = ep0_en_ff;
    end
    if (rd_en && hit_irq_stat) begin
      nxt_prdata[3:0] = irq_stat_ff;
    end
    if (rd_en && hit_irq_mask) begin
      nxt_prdata[3:0] = irq_mask_ff;
    end
    if (rd_en && hit_cause_view) begin
      nxt_prdata[3:0] = summaries;
    end
  end

  // Exactly one wait state per access
  always @* begin
    nxt_apb_state = apb_state_ff;
    case (apb_state_ff)
      APB_IDLE: begin
        if (psel && penable) begin
          nxt_apb_state = APB_DONE;
        end
      end
      APB_DONE: begin
        nxt_apb_state = APB_IDLE;
      end
      default: begin
        nxt_apb_state = APB_IDLE;
      end
    endcase
    nxt_pready = (nxt_apb_state == APB_DONE);
  end

  // Enable registers keep unused positions at zero
  always @* begin
    nxt_sie_en   = sie_en_ff;
    nxt_bulk_en  = bulk_en_ff;
    nxt_epsum_en = epsum_en_ff;
    nxt_ep0_en   = ep0_en_ff;
    nxt_irq_mask = irq_mask_ff;
    if (wr_en && hit_sie_en) begin
      nxt_sie_en = wbyte & `MASK_SIE_ENABLE;
    end
    if (wr_en && hit_bulk_en) begin
      nxt_bulk_en = wbyte & `MASK_BULK_ENABLE;
    end
    if (wr_en && hit_epsum_en) begin
      nxt_epsum_en = wbyte & `MASK_EP_SUM_ENABLE;
    end
    if (wr_en && hit_ep0_en) begin
      nxt_ep0_en = wbyte & `MASK_EP0_ENABLE;
    end
    if (wr_en && hit_irq_mask) begin
      nxt_irq_mask = wbyte[3:0];
    end
  end

  always @* begin
    nxt_reply_valid     = reply_wanted;
    nxt_reply_kind      = 2'b00;
    nxt_reply_drop_data = 1'b0;
    if (reply_wanted && token_is_ping) begin
      nxt_reply_kind = `HS_NAK;
    end else if (reply_wanted && token_iso) begin
      nxt_reply_kind      = `HS_NONE;
      nxt_reply_drop_data = 1'b1;
    end else if (reply_wanted) begin
      nxt_reply_kind = `HS_NAK;
    end
  end

  // Uses the status after this edge, so the line has no extra cycle of lag
  always @* begin
    nxt_irq = |(nxt_irq_stat & irq_mask_ff);
  end

  // Bus side: phase, answer and read data
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      apb_state_ff <= APB_IDLE;
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
    end else begin
      apb_state_ff <= nxt_apb_state;
      prdata       <= nxt_prdata;
      pready       <= nxt_pready;
      pslverr      <= nxt_pslverr;
    end
  end

  // Software-visible state
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unjoined_out_flag_ff <= 16'h0000;
      sie_en_ff            <= `RESET_BYTE;
      bulk_en_ff           <= `RESET_BYTE;
      epsum_en_ff          <= `RESET_BYTE;
      ep0_en_ff            <= `RESET_BYTE;
      irq_stat_ff          <= 4'h0;
      irq_mask_ff          <= 4'h0;
    end else begin
      unjoined_out_flag_ff <= nxt_unjoined_out_flag;
      sie_en_ff            <= nxt_sie_en;
      bulk_en_ff           <= nxt_bulk_en;
      epsum_en_ff          <= nxt_epsum_en;
      ep0_en_ff            <= nxt_ep0_en;
      irq_stat_ff          <= nxt_irq_stat;
      irq_mask_ff          <= nxt_irq_mask;
    end
  end

  // Handshake decision, one cycle after the token
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reply_valid     <= 1'b0;
      reply_kind      <= 2'b00;
      reply_drop_data <= 1'b0;
    end else begin
      reply_valid     <= nxt_reply_valid;
      reply_kind      <= nxt_reply_kind;
      reply_drop_data <= nxt_reply_drop_data;
    end
  end

  // Summaries lag their causes by one cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sie_cause_summary      <= 1'b0;
      bulk_cause_summary     <= 1'b0;
      endpoint_cause_summary <= 1'b0;
      ep0_cause_summary      <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      sie_cause_summary      <= sie_any;
      bulk_cause_summary     <= bulk_any;
      endpoint_cause_summary <= epsum_any;
      ep0_cause_summary      <= ep0_any;
      irq                    <= nxt_irq;
    end
  end

endmodule // alarm_out_irq

// >>> design/alarm_irq_map.vh
// How it works
// - Each unjoined-OUT flag is sticky; writing 1 clears it, writing 0 leaves it alone.
// - High flag register bits 7..0 are endpoints 15..8, low register bits 7..0 are endpoints 7..0.
// - An OUT token to an OUT-enabled endpoint with no area join sets its flag; endpoint 0 always counts as enabled.
// - For such a token with the iso select bit set, data is dropped and no handshake is sent.
// - For such a token with the iso select bit clear, the device answers NAK.
// - At high speed a PING to such an unjoined endpoint is answered with NAK.
// - The SIE enable register masks the SIE causes feeding the SIE summary bit.
// - The non-idle enable stays effective while the device sleeps.
// - The bulk enable register masks the bulk causes feeding the bulk summary bit.
// - Endpoint summary enable: bit 7 unjoined-IN group, bit 6 unjoined-OUT group, bits 4..0 endpoints e..a.
`ifndef ALARM_IRQ_MAP_VH
`define ALARM_IRQ_MAP_VH
`define OFS_ALARM_OUT_HIGH  8'hbe
`define OFS_ALARM_OUT_LOW   8'hbf
`define OFS_SIE_ENABLE      8'hc0
`define OFS_BULK_ENABLE     8'hc3
`define OFS_EP_SUM_ENABLE   8'hc4
`define OFS_EP0_ENABLE      8'hc5
`define OFS_IRQ_STATUS      8'he0
`define OFS_IRQ_MASK        8'he1
`define OFS_CAUSE_VIEW      8'he2
`define MASK_SIE_ENABLE     8'h7f
`define MASK_BULK_ENABLE    8'hec
`define MASK_EP_SUM_ENABLE  8'hdf
`define MASK_EP0_ENABLE     8'hff
`define RESET_BYTE          8'h00
`define BIT_UNJOINED_IN     7
`define BIT_UNJOINED_OUT    6
`define BIT_LINE_NOT_IDLE   6
`define HS_NAK              2'b01
`define HS_NONE             2'b10
`endif

// >>> design/masked_or.v
`timescale 1ns/1ps
module masked_or (
  // Cause and enable
  input  wire [7:0] cause,
  input  wire [7:0] enable,
  input  wire [7:0] keep,
  // Result
  output wire       any
);
  assign any = |(cause & enable & keep);
endmodule // masked_or

// >>> testbench/alarm_out_irq_assertions.sv
`timescale 1ns/1ps
`include "alarm_irq_map.vh"
module alarm_out_chk (
  // Watched design ports
  input wire        clk,
  input wire        rst_b,
  input wire        pready,
  input wire        token_valid,
  input wire        token_is_ping,
  input wire [3:0]  token_ep,
  input wire        high_speed_operation,
  input wire [15:0] out_endpoint_enable_mask,
  input wire [15:0] out_endpoint_iso_select,
  input wire [15:0] area_endpoint_join_bit,
  input wire [7:0]  sie_cause,
  input wire [7:0]  bulk_cause,
  input wire [7:0]  ep0_cause,
  input wire        reply_valid,
  input wire [1:0]  reply_kind,
  input wire        reply_drop_data,
  input wire        sie_cause_summary,
  input wire        bulk_cause_summary,
  input wire        ep0_cause_summary
);
  wire unj = (out_endpoint_enable_mask[token_ep] | token_ep == 4'h0) & ~area_endpoint_join_bit[token_ep];
  wire iso = out_endpoint_iso_select[token_ep];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_out; token_valid && !token_is_ping && unj; endsequence
  sequence s_ping; token_valid && token_is_ping && unj; endsequence
  property p_iso; s_out ##0 iso |=> reply_valid && reply_kind == `HS_NONE && reply_drop_data; endproperty
  property p_nak; s_out ##0 !iso |=> reply_valid && reply_kind == `HS_NAK && !reply_drop_data; endproperty
  property p_ping_hs; s_ping ##0 high_speed_operation |=> reply_valid && reply_kind == `HS_NAK; endproperty
  property p_ping_fs; token_valid && token_is_ping && !high_speed_operation |=> !reply_valid; endproperty
  property p_joined; token_valid && area_endpoint_join_bit[token_ep] |=> !reply_valid; endproperty
  property p_sie; sie_cause == 8'h00 [*2] |-> !sie_cause_summary; endproperty
  property p_bulk; (bulk_cause & 8'h13) == bulk_cause [*2] |-> !bulk_cause_summary; endproperty
  property p_ep0; ep0_cause == 8'h00 [*2] |-> !ep0_cause_summary; endproperty
  property p_rdy; pready |=> !pready; endproperty
  a_iso: assert property (p_iso) else $error("iso token reply wrong");
  a_nak: assert property (p_nak) else $error("out token reply wrong");
  a_ping_hs: assert property (p_ping_hs) else $error("ping reply wrong");
  a_ping_fs: assert property (p_ping_fs) else $error("full speed ping answered");
  a_joined: assert property (p_joined) else $error("joined endpoint answered");
  a_sie: assert property (p_sie) else $error("sie summary without cause");
  a_bulk: assert property (p_bulk) else $error("bulk summary from unused bit");
  a_ep0: assert property (p_ep0) else $error("ep0 summary without cause");
  a_rdy: assert property (p_rdy) else $error("ready longer than a cycle");
endmodule // alarm_out_chk
bind alarm_out_irq alarm_out_chk u_chk (.clk, .rst_b, .pready, .token_valid, .token_is_ping,
  .token_ep, .high_speed_operation, .out_endpoint_enable_mask, .out_endpoint_iso_select,
  .area_endpoint_join_bit, .sie_cause, .bulk_cause, .ep0_cause, .reply_valid, .reply_kind,
  .reply_drop_data, .sie_cause_summary, .bulk_cause_summary, .ep0_cause_summary);

// >>> testbench/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
  // Requests from the bench
  input  wire       clk,
  input  wire       go,
  input  wire       ping,
  input  wire [3:0] ep,
  // Token toward the device
  output reg        token_valid,
  output reg        token_is_ping,
  output reg  [3:0] token_ep
);
  initial {token_valid, token_is_ping, token_ep} = 6'h00;
  // Qualifiers churn between tokens so a stale value never passes
  always @(posedge clk) begin
    token_valid   <= go;
    token_is_ping <= go ? ping : ~token_is_ping;
    token_ep      <= go ? ep : token_ep + 4'h5;
  end
endmodule // usb_host_model

// >>> testbench/tb_usb_dev_alarm_out_irq_enables.sv
`timescale 1ns/1ps
module tb_usb_dev_alarm_out_irq_enables;
  reg         clk = 1'b0, rst_b, psel, penable, pwrite, go, ping, hs, slp, uin;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rn;
  reg  [15:0] en, iso, jn, fl;
  reg  [7:0]  sc, bc, ec;
  reg  [4:0]  epc;
  reg  [3:0]  gep;
  wire [31:0] prdata;
  wire [3:0]  tep;
  wire [1:0]  rk;
  wire        pready, pslverr, tv, tp, rv, rd, ss, bs, es, e0s, irq;
  integer     seed = 32'h20e6, miscompares = 0, num_checks = 0, cyc = 0, i, r;
  reg  [9:0]  qb[$];
  reg  [2:0]  qr[$];
  reg  [7:0]  ra[6] = '{8'hbe, 8'hbf, 8'hc0, 8'hc3, 8'hc4, 8'hc5};
  reg  [7:0]  rm[6] = '{8'h00, 8'h00, 8'h7f, 8'hec, 8'hdf, 8'hff};
  always #5 clk = ~clk;
  usb_host_model u_host (.clk(clk), .go(go), .ping(ping), .ep(gep), .token_valid(tv),
    .token_is_ping(tp), .token_ep(tep));
  alarm_out_irq u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .token_valid(tv), .token_is_ping(tp), .token_ep(tep),
    .high_speed_operation(hs), .sleep_state(slp), .out_endpoint_enable_mask(en),
    .out_endpoint_iso_select(iso), .area_endpoint_join_bit(jn), .sie_cause(sc),
    .bulk_cause(bc), .ep0_cause(ec), .ep_cause_any(epc), .unjoined_in_any(uin),
    .reply_valid(rv), .reply_kind(rk), .reply_drop_data(rd), .sie_cause_summary(ss),
    .bulk_cause_summary(bs), .endpoint_cause_summary(es), .ep0_cause_summary(e0s), .irq(irq));
  task automatic chk(input [31:0] g, input [31:0] x);
    num_checks++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task report_and_stop;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Register index times four gives the byte address
  task apb(input w, input [7:0] a, input [7:0] d, input e, input [7:0] x);
    qb.push_back({w, e, x});
    @(posedge clk);
    rn = $random(seed);
    psel <= 1'b1; pwrite <= w; paddr <= {2'b00, a, 2'b00}; pwdata <= {rn[23:0], d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task tok(input p, input [3:0] e);
    @(posedge clk);
    go <= 1'b1; ping <= p; gep <= e;
    if ((p ? hs : 1'b1) && (en[e] | e == 4'h0) && !jn[e]) qr.push_back(!p && iso[e] ? 3'h5 : 3'h2);
  endtask
  always @(posedge clk) if (rst_b) begin
    if (pready === 1'b1) begin
      chk(pslverr, qb[0][8]);
      if (!qb[0][9]) chk(prdata, qb[0][7:0]);
      void'(qb.pop_front());
    end
    if (rv === 1'b1) chk({rk, rd}, qr.size() ? qr.pop_front() : 3'h0);
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end
  initial begin
    {rst_b, psel, penable, pwrite, go, ping, hs, slp, uin} = 9'h000;
    {paddr, pwdata, en, iso, jn, sc, bc, ec, epc, gep} = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 6; i++) apb(0, ra[i], 8'h00, 0, 8'h00);
    for (i = 2; i < 6; i++) begin
      apb(1, ra[i], 8'hff, 0, 8'h00);
      apb(0, ra[i], 8'h00, 0, rm[i]);
    end
    apb(0, 8'h10, 8'h00, 1, 8'h00);
    $display("register test done");
    for (r = 0; r < 3; r++) begin
      @(posedge clk);
      en <= $random(seed) & 16'hfffe; iso <= $random(seed); jn <= $random(seed) & 16'hfffe;
      hs <= r[0];
      apb(1, 8'hbe, 8'hff, 0, 8'h00);
      apb(1, 8'hbf, 8'hff, 0, 8'h00);
      for (i = 0; i < 32; i++) tok(i[4], i[3:0]);
      @(posedge clk);
      go <= 1'b0;
      for (i = 0; i < 16; i++) fl[i] = (en[i] | i == 0) & ~jn[i];
      apb(0, 8'hbe, 8'h00, 0, fl[15:8]);
      apb(1, 8'hbf, 8'h00, 0, 8'h00);
      apb(0, 8'hbf, 8'h00, 0, fl[7:0]);
      apb(1, 8'hbf, 8'h0f, 0, 8'h00);
      apb(0, 8'hbf, 8'h00, 0, fl[7:0] & 8'hf0);
    end
    $display("token test done");
    @(posedge clk);
    sc <= 8'h80; bc <= 8'h13; ec <= $random(seed); epc <= $random(seed); uin <= 1'b0;
    repeat (3) @(posedge clk);
    chk(ss, 0);
    chk(bs, 0);
    chk(e0s, |ec);
    chk(es, (|epc) | (|fl[15:4]));
    slp <= 1'b1; sc <= 8'h3f;
    repeat (3) @(posedge clk);
    chk(ss, 0);
    sc <= 8'h40;
    repeat (3) @(posedge clk);
    chk(ss, 1);
    apb(0, 8'he2, 8'h00, 0, {4'h0, |ec, (|epc) | (|fl[15:4]), 2'b01});
    apb(1, 8'he0, 8'h0f, 0, 8'h00);
    apb(0, 8'he0, 8'h00, 0, {4'h0, |ec, (|epc) | (|fl[15:4]), 2'b01});
    chk(irq, 0);
    apb(1, 8'he1, 8'h0f, 0, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    apb(1, 8'he1, 8'h00, 0, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    $display("summary test done");
    chk(qr.size(), 0);
    report_and_stop;
  end
endmodule // tb_usb_dev_alarm_out_irq_enables
